// ==== rom_mirror_decode.sv ====
// Purpose: Memory map decode with bank 00 ROM mirror, RAM gap and ROM holes
// Assumes: CPU presents one request per cycle on the same clock
// Notes:   Result is registered, one cycle after the request
`timescale 1ns/100ps
module rom_mirror_decode
   import addr_decode_pkg::*;
(
   input  wire logic             core_clk,          // System clock
   input  wire logic             rst_b,             // Async reset, active low
   input  wire bus_req_t         cpu_req,           // CPU address request
   input  wire logic             mirror_size_select,// Mirror start select
   input  wire logic             ram_6k,            // RAM size strap, 1 = 6 KB
   input  wire logic             periph_use,        // Peripheral owns pin group
   input  wire logic [PIN_W-1:0] port_out,          // Port data out
   input  wire logic [PIN_W-1:0] port_oe,           // Port output enable
   input  wire logic [PIN_W-1:0] periph_out,        // Peripheral data out
   input  wire logic [PIN_W-1:0] periph_oe,         // Peripheral output enable
   output decode_t               dec_q,             // Registered decode result
   output logic                  dec_valid_q,       // Decode result valid
   output logic [15:0]           undef_data_q,      // Read value for empty space
   output logic      [PIN_W-1:0] pin_out_q,         // Shared pin data
   output logic      [PIN_W-1:0] pin_oe_q,          // Shared pin enable
   output logic                  port_live_q        // Pins usable as port
);

   ////////////////////////////////////////////////////////////////////////
   // Strap capture after reset release, never under the async branch
   logic ram_6k_q;
   logic strap_done_q;

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ram_6k_q     <= 1'b0;
         strap_done_q <= 1'b0;
      end
      else if (!strap_done_q)
      begin
         ram_6k_q     <= ram_6k;
         strap_done_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Combinational decode
   decode_t     dec_d;
   logic [23:0] ram_end;
   logic [15:0] mirror_lo;
   logic [7:0]  bank;
   logic [15:0] low;

   always_comb
   begin
      bank      = cpu_req.addr[23:16];
      low       = cpu_req.addr[15:0];
      ram_end   = ram_6k_q ? RAM_END_6K : RAM_END_4K;
      // Select at zero widens the window to 48 KB
      mirror_lo = mirror_size_select ? MIRROR_LO_HALF : MIRROR_LO_FULL;
      dec_d            = '0;
      dec_d.region     = REGION_NONE;
      dec_d.phys_addr  = cpu_req.addr;
      if (!cpu_req.valid)
         dec_d.region = REGION_NONE;
      else if (cpu_req.addr >= ram_end && cpu_req.addr <= INHIBIT_LAST)
         dec_d.region = REGION_INHIBIT;
      else if (bank == BANK_00 && low >= mirror_lo)
      begin
         dec_d.region    = REGION_MIRROR;
         dec_d.phys_addr = {BANK_FF, low};
      end
      else if ((cpu_req.addr >= HOLE0_FIRST && cpu_req.addr <= HOLE0_LAST) ||
               (cpu_req.addr >= HOLE1_FIRST && cpu_req.addr <= HOLE1_LAST))
         dec_d.region = REGION_HOLE;
      else if (cpu_req.addr >= ROM_BASE)
         dec_d.region = REGION_ROM;
      else
         dec_d.region = REGION_RAM_OR_IO;
      // Dead regions drop writes and read a fixed pattern
      if (dec_d.region == REGION_INHIBIT || dec_d.region == REGION_HOLE)
      begin
         dec_d.undef_read = cpu_req.valid && !cpu_req.write;
         dec_d.cell_en    = 1'b0;
         dec_d.write_en   = 1'b0;
      end
      else if (dec_d.region == REGION_NONE)
      begin
         dec_d.cell_en  = 1'b0;
         dec_d.write_en = 1'b0;
      end
      else
      begin
         dec_d.cell_en  = 1'b1;
         // ROM and its mirror never take writes
         dec_d.write_en = cpu_req.write && dec_d.region == REGION_RAM_OR_IO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dec_q       <= '0;
         dec_valid_q <= 1'b0;
      end
      else
      begin
         dec_q       <= dec_d;
         dec_valid_q <= cpu_req.valid;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         undef_data_q <= '0;
      else
         undef_data_q <= UNDEF_READ;
   end

   ////////////////////////////////////////////////////////////////////////
   // Shared pin ownership
   pin_owner_mux u_pin_mux (
      .core_clk    (core_clk),
      .rst_b       (rst_b),
      .periph_use  (periph_use),
      .port_out    (port_out),
      .port_oe     (port_oe),
      .periph_out  (periph_out),
      .periph_oe   (periph_oe),
      .pin_out_q   (pin_out_q),
      .pin_oe_q    (pin_oe_q),
      .port_live_q (port_live_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_mirror_maps_ff: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cpu_req.valid && cpu_req.addr[23:16] == BANK_00 && cpu_req.addr[15:0] >= MIRROR_LO_HALF &&
       !(cpu_req.addr >= RAM_END_4K && cpu_req.addr <= INHIBIT_LAST))
      |=> (dec_q.region == REGION_MIRROR &&
           dec_q.phys_addr == {BANK_FF, $past(cpu_req.addr[15:0])}))
      else $error("bank 00 mirror not mapped to bank FF");

   a_mirror_start_sel: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cpu_req.valid && mirror_size_select && cpu_req.addr == {BANK_00, MIRROR_LO_FULL})
      |=> dec_q.region == REGION_RAM_OR_IO)
      else $error("mirror started low with select set");

   a_mirror_full_win: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cpu_req.valid && !mirror_size_select && cpu_req.addr == {BANK_00, MIRROR_LO_FULL})
      |=> (dec_q.region == REGION_MIRROR && dec_q.phys_addr == {BANK_FF, MIRROR_LO_FULL}))
      else $error("48 KB mirror window missing");

   a_ram_gap_inhib: assert property (@(posedge core_clk) disable iff (!rst_b)
      (strap_done_q && cpu_req.valid && cpu_req.addr == INHIBIT_LAST)
      |=> (dec_q.region == REGION_INHIBIT && !dec_q.write_en))
      else $error("RAM gap not inhibited");

   a_rom_hole_empty: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cpu_req.valid && (cpu_req.addr[23:15] == HOLE0_FIRST[23:15] ||
                         cpu_req.addr[23:15] == HOLE1_FIRST[23:15]))
      |=> (dec_q.region == REGION_HOLE && !dec_q.cell_en))
      else $error("ROM hole mapped to cells");

   a_dead_write_drop: assert property (@(posedge core_clk) disable iff (!rst_b)
      (dec_q.region == REGION_INHIBIT || dec_q.region == REGION_HOLE)
      |-> (!dec_q.write_en && !dec_q.cell_en && undef_data_q == UNDEF_READ))
      else $error("write reached dead region");

   // Mirror is ROM, so a write there still enables the cell but must not set write_en
   a_mirror_no_write: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cpu_req.valid && cpu_req.write && cpu_req.addr[23:16] == BANK_00 &&
       cpu_req.addr[15:0] >= MIRROR_LO_HALF)
      |=> (dec_q.region == REGION_MIRROR && dec_q.cell_en && !dec_q.write_en))
      else $error("write reached mirrored ROM");

   a_half_below_start: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cpu_req.valid && mirror_size_select && cpu_req.addr[23:16] == BANK_00 &&
       cpu_req.addr[15:0] >= MIRROR_LO_FULL && cpu_req.addr[15:0] < MIRROR_LO_HALF)
      |=> (dec_q.region == REGION_RAM_OR_IO && dec_q.phys_addr == $past(cpu_req.addr)))
      else $error("mirror reached below its start with select set");

   a_full_below_start: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cpu_req.valid && !mirror_size_select && cpu_req.addr[23:16] == BANK_00 &&
       cpu_req.addr[15:0] < MIRROR_LO_FULL)
      |=> (dec_q.region != REGION_MIRROR))
      else $error("mirror reached below the wide window");

   // Lower part of bank FF has no image in bank 00
   a_ff_low_direct: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cpu_req.valid && cpu_req.addr[23:16] == BANK_FF &&
       cpu_req.addr[15:0] < MIRROR_LO_FULL)
      |=> (dec_q.region == REGION_ROM && dec_q.phys_addr == $past(cpu_req.addr)))
      else $error("lower bank FF ROM not reached directly");

   a_gap_start_4k: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cpu_req.valid && !ram_6k_q && cpu_req.addr == RAM_END_4K)
      |=> (dec_q.region == REGION_INHIBIT && !dec_q.cell_en))
      else $error("4 KB gap does not start at RAM end");

   a_gap_start_6k: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cpu_req.valid && ram_6k_q && cpu_req.addr == RAM_END_6K)
      |=> (dec_q.region == REGION_INHIBIT && !dec_q.cell_en))
      else $error("6 KB gap does not start at RAM end");

   // The larger RAM must stay reachable where the small part has its gap
   a_6k_ram_kept: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cpu_req.valid && ram_6k_q && cpu_req.addr >= RAM_END_4K &&
       cpu_req.addr < RAM_END_6K)
      |=> (dec_q.region == REGION_RAM_OR_IO && dec_q.cell_en))
      else $error("6 KB RAM cut by the small gap");

   a_ram_below_gap: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cpu_req.valid && cpu_req.addr < RAM_END_4K)
      |=> (dec_q.region == REGION_RAM_OR_IO && dec_q.write_en == $past(cpu_req.write)))
      else $error("RAM below the gap not served");

   a_idle_no_access: assert property (@(posedge core_clk) disable iff (!rst_b)
      !cpu_req.valid
      |=> (!dec_valid_q && dec_q.region == REGION_NONE && !dec_q.cell_en && !dec_q.write_en))
      else $error("idle cycle produced an access");

endmodule

// ==== addr_decode_pkg.sv ====
// Purpose: Shared constants and types for the memory map address decoder
// Assumes: 24-bit CPU bus addresses, one clock, active-low async reset
// Notes:   Address map constants, pin width, region codes, bus and decode structs
package addr_decode_pkg;

   localparam int ADDR_W = 24;
   localparam int PIN_W  = 8;

   localparam logic [23:0] RAM_END_4K     = 24'h00_1100;
   localparam logic [23:0] RAM_END_6K     = 24'h00_1900;
   localparam logic [23:0] INHIBIT_LAST   = 24'h00_1FFF;
   localparam logic [23:0] ROM_BASE       = 24'hFC_0000;
   localparam logic [23:0] HOLE0_FIRST    = 24'hFC_0000;
   localparam logic [23:0] HOLE0_LAST     = 24'hFC_7FFF;
   localparam logic [23:0] HOLE1_FIRST    = 24'hFE_0000;
   localparam logic [23:0] HOLE1_LAST     = 24'hFE_7FFF;
   localparam logic [15:0] MIRROR_LO_FULL = 16'h4000;
   localparam logic [15:0] MIRROR_LO_HALF = 16'h8000;
   localparam logic [7:0]  BANK_00        = 8'h00;
   localparam logic [7:0]  BANK_FF        = 8'hFF;
   localparam logic [15:0] UNDEF_READ     = 16'hFFFF;

   typedef enum logic [2:0] {
      REGION_NONE,
      REGION_RAM_OR_IO,
      REGION_INHIBIT,
      REGION_MIRROR,
      REGION_ROM,
      REGION_HOLE
   } region_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [23:0] addr;
   } bus_req_t;

   typedef struct packed {
      region_t     region;
      logic        cell_en;
      logic        write_en;
      logic [23:0] phys_addr;
      logic        undef_read;
   } decode_t;

endpackage

// ==== pin_owner_mux.sv ====
// Purpose: Hand one shared pin group to a peripheral or the general port
// Assumes: Ownership request comes from logic on the same clock
// Notes:   Peripheral always wins while it owns the group
`timescale 1ns/100ps
module pin_owner_mux
   import addr_decode_pkg::*;
(
   input  wire logic             core_clk,    // System clock
   input  wire logic             rst_b,       // Async reset, active low
   input  wire logic             periph_use,  // Peripheral claims the group
   input  wire logic [PIN_W-1:0] port_out,    // Port data out
   input  wire logic [PIN_W-1:0] port_oe,     // Port output enable
   input  wire logic [PIN_W-1:0] periph_out,  // Peripheral data out
   input  wire logic [PIN_W-1:0] periph_oe,   // Peripheral output enable
   output logic      [PIN_W-1:0] pin_out_q,   // Pin data out
   output logic      [PIN_W-1:0] pin_oe_q,    // Pin output enable, high drives
   output logic                  port_live_q  // Group usable as port
);

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_out_q   <= '0;
         pin_oe_q    <= '0;
         port_live_q <= 1'b0;
      end
      else if (periph_use)
      begin
         pin_out_q   <= periph_out;
         pin_oe_q    <= periph_oe;
         port_live_q <= 1'b0;
      end
      else
      begin
         pin_out_q   <= port_out;
         pin_oe_q    <= port_oe;
         port_live_q <= 1'b1;
      end
   end

   a_port_locked_out: assert property (@(posedge core_clk) disable iff (!rst_b)
      periph_use |=> (!port_live_q && pin_oe_q == $past(periph_oe)))
      else $error("port still live while peripheral owns pins");

   a_port_owns_free: assert property (@(posedge core_clk) disable iff (!rst_b)
      !periph_use |=> (port_live_q && pin_oe_q == $past(port_oe)))
      else $error("free pin group not handed to port");

endmodule

// ==== cpu_addr_source.sv ====
// Purpose: CPU side model that presents 24-bit bus requests to the decoder
// Assumes: Caller invokes the tasks just after a rising clock edge
// Notes:   Idle flips the address so a stale decode cannot pass by luck
`timescale 1ns/100ps
module cpu_addr_source
   import addr_decode_pkg::*;
(
   output bus_req_t cpu_req  // Request toward the decoder
);
   initial cpu_req = '0;

   task automatic issue(input bus_req_t r);
      cpu_req = r;
   endtask

   task automatic idle();
      cpu_req.valid = 1'b0;
      cpu_req.write = 1'b0;
      cpu_req.addr  = ~cpu_req.addr;
   endtask
endmodule

// ==== rom_mirror_decode_tb.sv ====
// Purpose: Self-checking bench for the memory map decoder
// Assumes: One request per cycle, result one edge later
// Notes:   Expectations come from the map rules, not from the design
`timescale 1ns/100ps
module rom_mirror_decode_tb
   import addr_decode_pkg::*;
;
   logic             core_clk, rst_b, mirror_size_select, ram_6k, periph_use;
   logic [PIN_W-1:0] port_out, port_oe, periph_out, periph_oe, pin_out_q, pin_oe_q;
   bus_req_t         cpu_req;
   decode_t          dec_q;
   logic             dec_valid_q, port_live_q;
   logic [15:0]      undef_data_q;
   int               num_errors, n_checks;

   initial core_clk = 1'b0;
   always #2.5 core_clk = ~core_clk;

   cpu_addr_source cpu_addr_source_inst (.cpu_req(cpu_req));
   rom_mirror_decode rom_mirror_decode_inst (.core_clk(core_clk), .rst_b(rst_b),
      .cpu_req(cpu_req), .mirror_size_select(mirror_size_select), .ram_6k(ram_6k),
      .periph_use(periph_use), .port_out(port_out), .port_oe(port_oe),
      .periph_out(periph_out), .periph_oe(periph_oe), .dec_q(dec_q),
      .dec_valid_q(dec_valid_q), .undef_data_q(undef_data_q), .pin_out_q(pin_out_q),
      .pin_oe_q(pin_oe_q), .port_live_q(port_live_q));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic [31:0] model(input bus_req_t r);
      region_t     g;
      logic        ce;
      logic [23:0] pa;
      pa = r.addr;
      if (!r.valid) g = REGION_NONE;
      else if (r.addr >= (ram_6k ? 24'h00_1900 : 24'h00_1100) && r.addr <= 24'h00_1FFF)
         g = REGION_INHIBIT;
      else if (r.addr[23:16] == 8'h00 && r.addr[15:0] >= (mirror_size_select ? 16'h8000
               : 16'h4000))
      begin
         g  = REGION_MIRROR;
         pa = {8'hFF, r.addr[15:0]};
      end
      else if ((r.addr >= 24'hFC_0000 && r.addr <= 24'hFC_7FFF)
               || (r.addr >= 24'hFE_0000 && r.addr <= 24'hFE_7FFF)) g = REGION_HOLE;
      else if (r.addr >= 24'hFC_0000) g = REGION_ROM;
      else g = REGION_RAM_OR_IO;
      ce = r.valid && g inside {REGION_MIRROR, REGION_ROM, REGION_RAM_OR_IO};
      return {2'b00, g, ce, ce && r.write && g == REGION_RAM_OR_IO,
              r.valid && !r.write && g inside {REGION_INHIBIT, REGION_HOLE},
              ce ? pa : 24'h00_0000};
   endfunction

   function automatic logic [31:0] seen_dec();
      return {2'b00, dec_q.region, dec_q.cell_en, dec_q.write_en, dec_q.undef_read,
              dec_q.cell_en ? dec_q.phys_addr : 24'h00_0000};
   endfunction

   // Back to back: the next request goes out in the step that checks this one
   task automatic probe(input logic wr, input logic [23:0] a);
      bus_req_t r;
      r = '{valid: 1'b1, write: wr, addr: a};
      cpu_addr_source_inst.issue(r);
      @(posedge core_clk);
      #1;
      chk(seen_dec(), model(r));
      chk({31'h0000_0000, dec_valid_q}, 32'h0000_0001);
      if (model(r) & 32'h0100_0000) chk({16'h0000, undef_data_q}, 32'h0000_FFFF);
   endtask

   task automatic do_reset(input logic six);
      cpu_addr_source_inst.idle();
      rst_b  = 1'b0;
      ram_6k = six;
      repeat (20) @(posedge core_clk);
      #1;
      chk({dec_valid_q, port_live_q, undef_data_q}, 32'h0000_0000);
      rst_b = 1'b1;
      @(posedge core_clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_mirror();
      mirror_size_select = 1'b0;
      probe(1'b0, 24'h00_3FFF);
      probe(1'b0, 24'h00_4000);
      probe(1'b0, 24'h00_C000);
      probe(1'b1, 24'h00_FFFF);
      probe(1'b0, 24'hFF_3FFF);
      mirror_size_select = 1'b1;
      probe(1'b0, 24'h00_4000);
      probe(1'b0, 24'h00_7FFF);
      probe(1'b0, 24'h00_8000);
      cpu_addr_source_inst.idle();
      @(posedge core_clk);
      #1;
      chk(seen_dec(), model(cpu_req));
      chk({31'h0000_0000, dec_valid_q}, 32'h0000_0000);
      $display("done: mirror");
   endtask

   task automatic t_gap();
      logic [23:0] first;
      first = ram_6k ? 24'h00_1900 : 24'h00_1100;
      probe(1'b1, first - 24'h00_0001);
      probe(1'b0, first);
      probe(1'b1, first);
      probe(1'b0, 24'h00_1FFF);
      probe(1'b1, 24'h00_2000);
      $display("done: gap ram_6k=%0d", ram_6k);
   endtask

   task automatic t_holes();
      logic [23:0] tbl [10] = '{24'hFB_FFFF, 24'hFC_0000, 24'hFC_7FFF, 24'hFC_8000,
         24'hFD_FFFF, 24'hFE_0000, 24'hFE_7FFF, 24'hFE_8000, 24'hFF_0000, 24'hFF_FFFF};
      foreach (tbl[i])
      begin
         probe(1'b0, tbl[i]);
         probe(1'b1, tbl[i]);
      end
      $display("done: holes");
   endtask

   task automatic t_pins();
      port_out   = 8'hA5;
      port_oe    = 8'h3C;
      periph_out = 8'h5A;
      periph_oe  = 8'hC3;
      for (int k = 0; k < 3; k++)
      begin
         periph_use = k[0];
         @(posedge core_clk);
         #1;
         chk({pin_out_q, pin_oe_q}, k[0] ? 16'h5AC3 : 16'hA53C);
         chk({31'h0000_0000, port_live_q}, {31'h0000_0000, ~k[0]});
      end
      $display("done: pins");
   endtask

   initial
   begin
      num_errors = 0;
      n_checks   = 0;
      rst_b      = 1'b0;
      ram_6k     = 1'b0;
      mirror_size_select = 1'b0;
      periph_use = 1'b0;
      port_out   = 8'h00;
      port_oe    = 8'h00;
      periph_out = 8'h00;
      periph_oe  = 8'h00;
      #1;
      do_reset(1'b0);
      t_mirror();
      t_gap();
      t_holes();
      t_pins();
      do_reset(1'b1);
      t_gap();
      t_mirror();
      tally_and_finish();
   end

   // Watchdog: a stuck run is counted and closed
   initial
   begin
      repeat (5000) @(posedge core_clk);
      num_errors++;
      tally_and_finish();
   end
endmodule
